// ===== verilog/eif_pkg.sv
// Summary of operation
// - edge select 1 on external pin three detects rising edges as events
// - shared edge select 1 detects rising edges on wake input seven and timer-y input
// - eight read/write wake enable bits, positions 7..0, reset to zero
// - timer b1 flag sets when the counter wraps from maximum to zero
// - writing 0 to the set timer b1 flag clears it
// - request flags accept only a write of 0; writing 1 leaves them unchanged
package eif_pkg;
  // byte addresses of the registers
  localparam logic [7:0] ADDR_EDGE = 8'h00;
  localparam logic [7:0] ADDR_WAKE_EN = 8'h04;
  localparam logic [7:0] ADDR_FLAGS = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_MASK = 8'h10;
  localparam logic [7:0] ADDR_TIMER = 8'h14;
  // edge register fields
  localparam int EDGE_PIN3_BIT = 0;
  localparam int EDGE_WAKE7_BIT = 1;
  // flag register layout: bits 7..0 wake flags, bit 8 pin three, bit 9 timer b1
  localparam int FLAG_PIN3_BIT = 8;
  localparam int FLAG_TB1_BIT = 9;
  localparam int FLAG_W = 10;
  // reset values, timer maximum and response codes
  localparam logic [1:0] EDGE_RST = 2'h0;
  localparam logic [7:0] WAKE_EN_RST = 8'h00;
  localparam logic [9:0] FLAG_RST = 10'h000;
  localparam logic [7:0] TIMER_MAX = 8'hFF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== verilog/eif_edge_det.sv
`timescale 1ns/100ps
// two-stage synchroniser plus selectable edge detector
module eif_edge_det (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // pin and select
  input wire logic pin,
  input wire logic rise_sel,
  // detected event, one cycle
  output logic event_pulse
);
  logic sync1;
  logic sync2;
  logic last;
  wire rise = sync2 & ~last;
  wire fall = ~sync2 & last;
  // only sync2 is looked at; sync1 feeds nothing else
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      last <= 1'b0;
      event_pulse <= 1'b0;
    end else begin
      sync1 <= pin;
      sync2 <= sync1;
      last <= sync2;
      event_pulse <= rise_sel ? rise : fall;
    end
  end
endmodule

// ===== verilog/eif_top.sv
`timescale 1ns/100ps
// interrupt enable and request flag block with an axi4-lite slave
module eif_top (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // external pins
  input wire logic ext_irq_pin_three,
  input wire logic [7:0] wake_inputs,
  input wire logic timer_y_event_input,
  // timer b1 count step from the timer logic, same clock
  input wire logic timer_b1_tick,
  // interrupts
  output logic cpu_irq,
  output logic [7:0] wake_irq_req,
  output logic pin3_irq_req,
  output logic tb1_irq_req
);
  // registers
  logic [1:0] edge_sel;
  logic [7:0] wake_enable;
  logic [9:0] flags;
  logic [9:0] status;
  logic [9:0] mask;
  logic [7:0] tb1_count;
  // write channel holding
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  // detected events
  logic pin3_ev;
  logic [7:0] wake_ev;
  logic tmy_ev;

  // pin three detector
  eif_edge_det u_pin3 (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(ext_irq_pin_three),
    .rise_sel(edge_sel[eif_pkg::EDGE_PIN3_BIT]),
    .event_pulse(pin3_ev)
  );

  // wake inputs 0..6 use falling edges; seven follows the shared select
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_wake
      eif_edge_det u_wake (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin(wake_inputs[gi]),
        .rise_sel((gi == 7) ? edge_sel[eif_pkg::EDGE_WAKE7_BIT] : 1'b0),
        .event_pulse(wake_ev[gi])
      );
    end
  endgenerate

  // timer-y event input shares the seven select
  eif_edge_det u_tmy (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(timer_y_event_input),
    .rise_sel(edge_sel[eif_pkg::EDGE_WAKE7_BIT]),
    .event_pulse(tmy_ev)
  );

  // one match list for both bus directions, so no register answers on one side only
  function automatic logic addr_mapped(input logic [7:0] addr);
    logic hit;
    hit = 1'b0;
    if (addr == eif_pkg::ADDR_EDGE) begin
      hit = 1'b1;
    end else if (addr == eif_pkg::ADDR_WAKE_EN) begin
      hit = 1'b1;
    end else if (addr == eif_pkg::ADDR_FLAGS) begin
      hit = 1'b1;
    end else if (addr == eif_pkg::ADDR_STATUS) begin
      hit = 1'b1;
    end else if (addr == eif_pkg::ADDR_MASK) begin
      hit = 1'b1;
    end else if (addr == eif_pkg::ADDR_TIMER) begin
      hit = 1'b1;
    end
    return hit;
  endfunction

  // write data cut to the enabled byte lanes; bits 9..8 ride on lane one
  function automatic logic [9:0] lane_bits(input logic [31:0] data, input logic [3:0] strb);
    return data[9:0] & {{2{strb[1]}}, {8{strb[0]}}};
  endfunction

  // read selection; every register is an argument so the assignment tracks each change
  function automatic logic [31:0] read_word(input logic [7:0] addr, input logic [1:0] sel,
      input logic [7:0] en, input logic [9:0] flg, input logic [9:0] st,
      input logic [9:0] msk, input logic [7:0] cnt);
    logic [31:0] word;
    word = 32'h0000_0000;
    if (addr == eif_pkg::ADDR_EDGE) begin
      word = {30'h0, sel};
    end else if (addr == eif_pkg::ADDR_WAKE_EN) begin
      word = {24'h00_0000, en};
    end else if (addr == eif_pkg::ADDR_FLAGS) begin
      word = {22'h00_0000, flg};
    end else if (addr == eif_pkg::ADDR_STATUS) begin
      word = {22'h00_0000, st};
    end else if (addr == eif_pkg::ADDR_MASK) begin
      word = {22'h00_0000, msk};
    end else if (addr == eif_pkg::ADDR_TIMER) begin
      word = {24'h00_0000, cnt};
    end
    return word;
  endfunction

  // write decode: fire once both halves are held and no response waits
  wire do_write = aw_held & w_held & ~s_axi_bvalid;
  wire wr_edge = do_write & (aw_addr == eif_pkg::ADDR_EDGE) & w_strb[0];
  wire wr_en = do_write & (aw_addr == eif_pkg::ADDR_WAKE_EN) & w_strb[0];
  wire wr_flag = do_write & (aw_addr == eif_pkg::ADDR_FLAGS);
  wire wr_stat = do_write & (aw_addr == eif_pkg::ADDR_STATUS);
  wire wr_mask = do_write & (aw_addr == eif_pkg::ADDR_MASK);
  // unmapped offsets still complete, only with an error response
  wire wr_known = addr_mapped(aw_addr);
  wire [9:0] lane_mask = {{2{w_strb[1]}}, {8{w_strb[0]}}};

  // flag clear: a zero in an enabled lane clears; a one does nothing
  wire [9:0] flag_clr = wr_flag ? lane_bits(~w_data, w_strb) : 10'h000;
  wire tb1_wrap = timer_b1_tick & (tb1_count == eif_pkg::TIMER_MAX);
  wire [9:0] flag_set = {tb1_wrap, pin3_ev, wake_ev | {tmy_ev, 7'h00}};
  // set wins over clear so a same-cycle event is kept
  wire [9:0] next_flags = (flags & ~flag_clr) | flag_set;

  // enables per flag: wake flags gated by wake enable, others always on
  wire [9:0] flag_en = {2'h3, wake_enable};
  wire [9:0] req = flags & flag_en;
  // status mirrors enabled requests rising; cleared by writing one
  wire [9:0] stat_clr = wr_stat ? lane_bits(w_data, w_strb) : 10'h000;
  wire [9:0] next_status = (status & ~stat_clr) | (flag_set & flag_en);
  wire [9:0] next_mask = wr_mask ? (lane_bits(w_data, w_strb) | (mask & ~lane_mask)) : mask;

  // read decode
  wire rd_fire = s_axi_arvalid & s_axi_arready;
  wire [31:0] rd_word = read_word(s_axi_araddr, edge_sel, wake_enable, flags, status, mask,
    tb1_count);
  wire rd_known = addr_mapped(s_axi_araddr);

  // write address and data capture, either order
  // ready drops after a handshake so a held half is never overwritten
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= ~aw_held & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready <= ~w_held & ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  // write response; unmapped addresses answer slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= eif_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_known ? eif_pkg::RESP_OKAY : eif_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read channel: one read at a time, answered one cycle after acceptance
  // rdata loads only on acceptance, so it stands while rvalid waits for rready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= eif_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~rd_fire;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_known ? eif_pkg::RESP_OKAY : eif_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // edge select; a change acts on the next synchronised sample
  // a change while a pin sits mid-transition may miss or add one event
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      edge_sel <= eif_pkg::EDGE_RST;
    end else if (wr_edge) begin
      edge_sel <= w_data[1:0];
    end
  end

  // wake enable bits, lane zero only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_enable <= eif_pkg::WAKE_EN_RST;
    end else if (wr_en) begin
      wake_enable <= w_data[7:0];
    end
  end

  // status mask for the cpu line
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask <= eif_pkg::FLAG_RST;
    end else begin
      mask <= next_mask;
    end
  end

  // timer b1 counter; wraps from maximum to zero
  // a local copy of the count, read back so software can see the wrap point
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tb1_count <= 8'h00;
    end else if (timer_b1_tick) begin
      tb1_count <= tb1_count + 8'h01;
    end
  end

  // flags and status; set wins over a same-cycle clear in both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags <= eif_pkg::FLAG_RST;
      status <= eif_pkg::FLAG_RST;
    end else begin
      flags <= next_flags;
      status <= next_status;
    end
  end

  // per-source request lines, registered so every output leaves a flip-flop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_irq_req <= 8'h00;
      pin3_irq_req <= 1'b0;
      tb1_irq_req <= 1'b0;
    end else begin
      wake_irq_req <= req[7:0];
      pin3_irq_req <= req[eif_pkg::FLAG_PIN3_BIT];
      tb1_irq_req <= req[eif_pkg::FLAG_TB1_BIT];
    end
  end

  // cpu line; one cycle behind status, the price of a registered output
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_irq <= 1'b0;
    end else begin
      cpu_irq <= |(status & mask);
    end
  end
endmodule

// ===== verification/eif_top_sva.sv
`timescale 1ns/100ps
// bus handshake and event timing checks at the block boundary
module eif_top_sva (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus handshakes
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // events and requests
  input wire logic ext_irq_pin_three,
  input wire logic timer_b1_tick,
  input wire logic pin3_irq_req,
  input wire logic tb1_irq_req
);
  logic [3:0] w_age;
  logic [3:0] p_age;
  logic pin_q;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // saturating ages bound the event latencies without long repetitions
  always_ff @(posedge aclk) begin
    pin_q <= ext_irq_pin_three;
    if (!aresetn) w_age <= 4'hF;
    else if (s_axi_wvalid && s_axi_wready) w_age <= 4'h0;
    else if (w_age != 4'hF) w_age <= w_age + 4'h1;
    if (!aresetn) p_age <= 4'hF;
    else if (pin_q != ext_irq_pin_three) p_age <= 4'h0;
    else if (p_age != 4'hF) p_age <= p_age + 4'h1;
  end
  property p_b_one; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_b_one: assert property (p_b_one) else $error("write response repeated");
  property p_r_one; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_r_one: assert property (p_r_one) else $error("read data repeated");
  property p_rd_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read data late");
  property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_ar_block: assert property (p_ar_block) else $error("read address taken while busy");
  property p_wr_lat; s_axi_wvalid && s_axi_wready |-> ##[1:4] s_axi_bvalid; endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write response late");
  property p_pin3_rise; $rose(pin3_irq_req) |-> p_age >= 4'h2 && p_age <= 4'h6; endproperty
  a_pin3_rise: assert property (p_pin3_rise) else $error("pin request off its edge");
  property p_tb1_rise;
    $rose(tb1_irq_req) |-> $past(timer_b1_tick) || $past(timer_b1_tick, 2);
  endproperty
  a_tb1_rise: assert property (p_tb1_rise) else $error("timer flag without a step");
  property p_tb1_fall; $fell(tb1_irq_req) |-> w_age <= 4'h5; endproperty
  a_tb1_fall: assert property (p_tb1_fall) else $error("timer flag lost");
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == eif_pkg::RESP_SLVERR);
  c_pin3: cover property ($rose(pin3_irq_req));
  c_tb1: cover property ($fell(tb1_irq_req));
endmodule
bind eif_top eif_top_sva eif_top_sva_inst (.*);

// ===== verification/eif_cpu_model.sv
`timescale 1ns/100ps
// cpu side of the register bus, one access at a time
module eif_cpu_model (
  // clock
  input wire logic aclk,
  // requests
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  output logic s_axi_rready,
  // answers
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid
);
  // idle bus from time zero
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
  end
  // released payload is inverted so a stale value never looks valid
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
      output logic [1:0] r);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awready) {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
      if (s_axi_wready) {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~d};
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_arready) {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
    end while (!s_axi_rvalid);
    {d, r} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask
endmodule

// ===== verification/test_eif_top.sv
`timescale 1ns/100ps
// register, pin and timer checks of the interrupt enable block
module test_eif_top;
  logic aclk, aresetn, ext_irq_pin_three, timer_y_event_input, timer_b1_tick;
  logic [7:0] s_axi_awaddr, s_axi_araddr, wake_inputs, wake_irq_req;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic cpu_irq, pin3_irq_req, tb1_irq_req;
  int num_errors = 0;
  int checks = 0;
  eif_top eif_top_inst (.*);
  eif_cpu_model eif_cpu_model_inst (.*);
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    eif_cpu_model_inst.wr(a, d, 4'hF, r);
    chk("bresp", {30'h0, r}, {30'h0, er});
    repeat (6) @(posedge aclk);
  endtask
  // write with chosen byte lanes, then let the outputs settle
  task automatic wrs(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [1:0] r;
    eif_cpu_model_inst.wr(a, d, s, r);
    chk("bresp", {30'h0, r}, {30'h0, eif_pkg::RESP_OKAY});
    repeat (2) @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    eif_cpu_model_inst.rd(a, d, r);
    chk("rresp", {30'h0, r}, {30'h0, er});
    chk("rdata", d, e);
  endtask
  // pin change, then wait out sync, edge and flag stages
  task automatic pins(input logic p3, input logic [7:0] w, input logic ty);
    @(posedge aclk) {ext_irq_pin_three, wake_inputs, timer_y_event_input} <= {p3, w, ty};
    repeat (6) @(posedge aclk);
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // hang guard, far beyond the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    wrap_up;
  end
  initial begin
    {aresetn, ext_irq_pin_three, timer_y_event_input, timer_b1_tick} = 4'h0;
    wake_inputs = 8'hFF;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(eif_pkg::ADDR_WAKE_EN, 32'h0, eif_pkg::RESP_OKAY);
    wr(eif_pkg::ADDR_WAKE_EN, 32'hFFFF_FFA5, eif_pkg::RESP_OKAY);
    rd(eif_pkg::ADDR_WAKE_EN, 32'hA5, eif_pkg::RESP_OKAY);
    wr(8'h40, 32'hFFFF_FFFF, eif_pkg::RESP_SLVERR);
    rd(8'h40, 32'h0, eif_pkg::RESP_SLVERR);
    wr(eif_pkg::ADDR_EDGE, 32'h3, eif_pkg::RESP_OKAY);
    wr(eif_pkg::ADDR_WAKE_EN, 32'h81, eif_pkg::RESP_OKAY);
    pins(1'b0, 8'hFC, 1'b0);
    chk("wake_irq_req", {24'h0, wake_irq_req}, 32'h01);
    pins(1'b0, 8'hFC, 1'b1);
    chk("wake_irq_req", {24'h0, wake_irq_req}, 32'h81);
    wr(eif_pkg::ADDR_FLAGS, 32'h37F, eif_pkg::RESP_OKAY);
    chk("wake_irq_req", {24'h0, wake_irq_req}, 32'h01);
    pins(1'b0, 8'h7C, 1'b1);
    chk("wake_irq_req", {24'h0, wake_irq_req}, 32'h01);
    pins(1'b0, 8'hFC, 1'b1);
    chk("wake_irq_req", {24'h0, wake_irq_req}, 32'h81);
    pins(1'b1, 8'hFC, 1'b1);
    chk("pin3_irq_req", {31'h0, pin3_irq_req}, 32'h1);
    wr(eif_pkg::ADDR_FLAGS, 32'h2FF, eif_pkg::RESP_OKAY);
    pins(1'b0, 8'hFC, 1'b1);
    chk("pin3_irq_req", {31'h0, pin3_irq_req}, 32'h0);
    @(posedge aclk) timer_b1_tick <= 1'b1;
    repeat (255) @(posedge aclk);
    timer_b1_tick <= 1'b0;
    rd(eif_pkg::ADDR_TIMER, 32'hFF, eif_pkg::RESP_OKAY);
    chk("tb1_irq_req", {31'h0, tb1_irq_req}, 32'h0);
    @(posedge aclk) timer_b1_tick <= 1'b1;
    @(posedge aclk) timer_b1_tick <= 1'b0;
    rd(eif_pkg::ADDR_TIMER, 32'h0, eif_pkg::RESP_OKAY);
    chk("tb1_irq_req", {31'h0, tb1_irq_req}, 32'h1);
    wr(eif_pkg::ADDR_FLAGS, 32'h3FF, eif_pkg::RESP_OKAY);
    chk("tb1_irq_req", {31'h0, tb1_irq_req}, 32'h1);
    wr(eif_pkg::ADDR_FLAGS, 32'h1FF, eif_pkg::RESP_OKAY);
    chk("tb1_irq_req", {31'h0, tb1_irq_req}, 32'h0);
    rd(eif_pkg::ADDR_STATUS, 32'h381, eif_pkg::RESP_OKAY);
    chk("cpu_irq", {31'h0, cpu_irq}, 32'h0);
    wr(eif_pkg::ADDR_MASK, 32'h200, eif_pkg::RESP_OKAY);
    chk("cpu_irq", {31'h0, cpu_irq}, 32'h1);
    wr(eif_pkg::ADDR_STATUS, 32'h200, eif_pkg::RESP_OKAY);
    chk("cpu_irq", {31'h0, cpu_irq}, 32'h0);
    rd(eif_pkg::ADDR_STATUS, 32'h181, eif_pkg::RESP_OKAY);
    wrs(eif_pkg::ADDR_EDGE, 32'h0, 4'hE);
    rd(eif_pkg::ADDR_EDGE, 32'h3, eif_pkg::RESP_OKAY);
    wrs(eif_pkg::ADDR_FLAGS, 32'h0, 4'h2);
    chk("wake_irq_req", {24'h0, wake_irq_req}, 32'h81);
    wrs(eif_pkg::ADDR_FLAGS, 32'h0, 4'h1);
    chk("wake_irq_req", {24'h0, wake_irq_req}, 32'h0);
    wrap_up;
  end
endmodule
